// *** verilog/lsd_ctrl.sv ***
// serial command port, display memory and scan timing of the led driver
`include "lsd_regs.svh"

module lsd_ctrl
  import lsd_pkg::*;
#(
  parameter int DISP_CYC = `LSD_DISP_CYCLE_CYC
)
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic transfer_select_in,
  input wire logic serial_clk_in,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_out,
  input wire logic [1:0] key_return_in,
  output logic [7:0] segment_out,
  output logic [6:0] digit_drive_out,
  output logic key_scan_line_active_out
);

  localparam logic [10:0] SLOT_LAST =
    11'(DISP_CYC / `LSD_DIM_SLOTS - 1);
  localparam logic [10:0] KEY_LAST =
    11'(`LSD_KEY_CYCLE_CYC / `LSD_KEY_LINES - 1);
  localparam logic [3:0] KEY_IDX_LAST = 4'(`LSD_KEY_LINES - 1);
  localparam logic [3:0] SLOT_IDX_LAST = 4'(`LSD_DIM_SLOTS - 1);

  lsd_state_t st_reg;
  lsd_state_t st_next;

  // on-time in slots for a dim code
  function automatic logic [4:0] on_slots(input logic [3:0] code);
    logic [4:0] s;
    s = 5'h0;
    unique case (code[2:0])
      3'h0: s = 5'h01;
      3'h1: s = 5'h02;
      3'h2: s = 5'h04;
      3'h3: s = 5'h0A;
      3'h4: s = 5'h0B;
      3'h5: s = 5'h0C;
      3'h6: s = 5'h0D;
      3'h7: s = 5'h0E;
    endcase
    return s;
  endfunction

  // highest location of a page
  function automatic logic [2:0] page_last(input logic [1:0] pg);
    logic [2:0] l;
    l = `LSD_LAST_DIM;
    unique case (pg)
      `LSD_PAGE_SEG: l = `LSD_LAST_SEG;
      `LSD_PAGE_LED: l = `LSD_LAST_LED;
      `LSD_PAGE_DIGDIM: l = `LSD_LAST_DIM;
      `LSD_PAGE_LEDDIM: l = `LSD_LAST_DIM;
    endcase
    return l;
  endfunction

  // readback mux
  function automatic logic [7:0] read_byte(input lsd_state_t s);
    logic [7:0] b;
    b = 8'h00;
    if (s.ptr <= page_last(s.page))
    begin
      unique case (s.page)
        `LSD_PAGE_SEG: b = s.seg_mem[s.ptr];
        `LSD_PAGE_LED:
        begin
          unique case (s.ptr)
            `LSD_ADDR_KEY1: b = s.keys[7:0];
            `LSD_ADDR_KEY2: b = s.keys[15:8];
            default: b = s.led_mem;
          endcase
        end
        `LSD_PAGE_DIGDIM: b = s.dig_dim[s.ptr[1:0]];
        `LSD_PAGE_LEDDIM: b = s.led_dim[s.ptr[1:0]];
      endcase
    end
    return b;
  endfunction

  always_comb
  begin
    logic rise;
    logic fall;
    logic [7:0] byte_in;
    logic [7:0] rb;
    logic [1:0] bmode;
    logic [2:0] ndig;
    logic [3:0] code;
    logic [7:0] gate;
    logic [7:0] src;
    logic phase_end;
    logic [10:0] sub_last;
    logic [3:0] idx_last;
    rise = 1'b0;
    fall = 1'b0;
    byte_in = 8'h00;
    rb = 8'h00;
    bmode = 2'h0;
    ndig = 3'h0;
    code = 4'h0;
    gate = 8'h00;
    src = 8'h00;
    phase_end = 1'b0;
    sub_last = 11'h0;
    idx_last = 4'h0;
    st_next = st_reg;

    // pin synchronisers
    st_next.stb_s = {st_reg.stb_s[1:0], transfer_select_in};
    st_next.sclk_s = {st_reg.sclk_s[1:0], serial_clk_in};
    st_next.din_s = {st_reg.din_s[0], data_in};
    st_next.key1_s = {st_reg.key1_s[0], key_return_in[0]};
    st_next.key2_s = {st_reg.key2_s[0], key_return_in[1]};
    rise = st_reg.sclk_s[1] & ~st_reg.sclk_s[2];
    fall = ~st_reg.sclk_s[1] & st_reg.sclk_s[2];

    // serial port
    if (st_reg.stb_s[1])
    begin
      st_next.ser = SER_IDLE;
      st_next.bits = 3'h0;
      st_next.pend = 1'b0;
      st_next.pins.data_oe = 1'b0;
    end
    else
    begin
      if (st_reg.ser == SER_IDLE)
        st_next.ser = SER_CMD;
      if (rise && !(st_reg.ser == SER_DATA && st_reg.rd))
      begin
        byte_in = {st_reg.din_s[1], st_reg.shift[7:1]};
        st_next.shift = byte_in;
        st_next.bits = st_reg.bits + 3'h1;
        if (st_reg.bits == 3'h7)
        begin
          if (st_reg.ser != SER_DATA)
          begin
            st_next.ptr = byte_in[`LSD_CMD_ADDR_LSB +: 3];
            st_next.page = byte_in[`LSD_CMD_PAGE_LSB +: 2];
            st_next.fixed = byte_in[`LSD_CMD_FIXED_BIT];
            st_next.rd = byte_in[`LSD_CMD_READ_BIT];
            st_next.pend = byte_in[`LSD_CMD_READ_BIT];
            st_next.ser = SER_DATA;
          end
          else
          begin
            if (st_reg.ptr <= page_last(st_reg.page))
            begin
              unique case (st_reg.page)
                `LSD_PAGE_SEG:
                  st_next.seg_mem[st_reg.ptr] = byte_in;
                `LSD_PAGE_LED:
                begin
                  if (st_reg.ptr == `LSD_ADDR_LEDDATA)
                  begin
                    st_next.led_mem = byte_in;
                    st_next.led_written = 1'b1;
                  end
                end
                `LSD_PAGE_DIGDIM:
                  st_next.dig_dim[st_reg.ptr[1:0]] = byte_in;
                `LSD_PAGE_LEDDIM:
                  st_next.led_dim[st_reg.ptr[1:0]] = byte_in;
              endcase
            end
            if (!st_reg.fixed)
              st_next.ptr = (st_reg.ptr >= page_last(st_reg.page)) ?
                3'h0 : st_reg.ptr + 3'h1;
          end
        end
      end
      if (fall && st_reg.ser == SER_DATA && st_reg.rd)
      begin
        st_next.pins.data_oe = 1'b1;
        if (st_reg.pend || st_reg.tx_bits == 3'h7)
        begin
          rb = read_byte(st_reg);
          st_next.pins.data = rb[0];
          st_next.tx = {1'b0, rb[7:1]};
          st_next.tx_bits = 3'h0;
          st_next.pend = 1'b0;
          if (!st_reg.fixed)
            st_next.ptr = (st_reg.ptr >= page_last(st_reg.page)) ?
              3'h0 : st_reg.ptr + 3'h1;
        end
        else
        begin
          st_next.pins.data = st_reg.tx[0];
          st_next.tx = {1'b0, st_reg.tx[7:1]};
          st_next.tx_bits = st_reg.tx_bits + 3'h1;
        end
      end
    end

    // scan timer, never stopped
    if (st_reg.phase == PH_KEY)
    begin
      sub_last = KEY_LAST;
      idx_last = KEY_IDX_LAST;
    end
    else
    begin
      sub_last = SLOT_LAST;
      idx_last = SLOT_IDX_LAST;
    end
    phase_end = (st_reg.sub == sub_last) && (st_reg.idx == idx_last);
    if (st_reg.sub == sub_last)
    begin
      st_next.sub = 11'h0;
      st_next.idx = st_reg.idx + 4'h1;
      if (st_reg.phase == PH_KEY)
      begin
        st_next.keys[st_reg.idx[2:0]] = st_reg.key1_s[1];
        st_next.keys[{1'b1, st_reg.idx[2:0]}] = st_reg.key2_s[1];
      end
    end
    else
      st_next.sub = st_reg.sub + 11'h1;

    ndig = st_reg.dig_dim[0][`LSD_DIGITS_LSB +: 3];
    if (ndig > `LSD_MAX_DIGCODE)
      ndig = `LSD_MAX_DIGCODE;
    if (phase_end)
    begin
      st_next.idx = 4'h0;
      st_next.digit_drive = 3'h0;
      unique case (st_reg.phase)
        PH_KEY: st_next.phase = st_reg.led_written ? PH_LED : PH_DIG;
        PH_LED: st_next.phase = PH_DIG;
        PH_DIG:
        begin
          if (st_reg.digit_drive >= ndig)
            st_next.phase = PH_KEY;
          else
          begin
            st_next.phase = PH_DIG;
            st_next.digit_drive = st_reg.digit_drive + 3'h1;
          end
        end
        default: st_next.phase = PH_KEY;
      endcase
    end

    // dimming and drive
    bmode = st_reg.dig_dim[0][`LSD_BRIGHT_LSB +: 2];
    for (int i = 0; i < 8; i++)
    begin
      if (bmode == `LSD_BRIGHT_VAR)
      begin
        if (st_reg.phase == PH_LED)
          code = st_reg.led_dim[i / 2][(i % 2) * 4 +: 4];
        else
          code = st_reg.dig_dim[st_reg.digit_drive[2:1] + 2'h1]
            [st_reg.digit_drive[0] * 4 +: 4];
      end
      else
        code = {1'b0,
          st_reg.dig_dim[0][`LSD_CONSTDIM_LSB +: 3]};
      gate[i] = {1'b0, st_reg.idx} < on_slots(code);
    end
    st_next.pins.digit = 7'h00;
    st_next.pins.key_active = 1'b0;
    unique case (st_reg.phase)
      PH_KEY:
      begin
        st_next.pins.key_active = 1'b1;
        src = 8'h01 << st_reg.idx[2:0];
        st_next.pins.segment = src;
      end
      PH_LED:
      begin
        st_next.pins.digit[0] = 1'b1;
        st_next.pins.segment = st_reg.led_mem & gate;
      end
      PH_DIG:
      begin
        st_next.pins.digit = 7'h02 << st_reg.digit_drive;
        st_next.pins.segment =
          st_reg.seg_mem[st_reg.digit_drive] & gate;
      end
      default: st_next.pins.segment = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_reg <= '0;
      st_reg.dig_dim[0] <= `LSD_MODE_RESET;
      st_reg.ser <= SER_IDLE;
      st_reg.phase <= PH_KEY;
      st_reg.stb_s <= 3'h7;
      // idle level of the serial clock pin, no false rise after reset
      st_reg.sclk_s <= 3'h7;
    end
    else
      st_reg <= st_next;
  end

  assign data_out = st_reg.pins.data;
  assign data_oe_out = st_reg.pins.data_oe;
  assign segment_out = st_reg.pins.segment;
  assign digit_drive_out = st_reg.pins.digit;
  assign key_scan_line_active_out = st_reg.pins.key_active;

endmodule

// *** verilog/lsd_regs.svh ***
// constants for the led scan display controller
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

// pages named by the command byte
`define LSD_PAGE_SEG 2'h0
`define LSD_PAGE_LED 2'h1
`define LSD_PAGE_DIGDIM 2'h2
`define LSD_PAGE_LEDDIM 2'h3

// highest location in each page
`define LSD_LAST_SEG 3'h5
`define LSD_LAST_LED 3'h2
`define LSD_LAST_DIM 3'h3

// locations
`define LSD_ADDR_MODE 3'h0
`define LSD_ADDR_LEDDATA 3'h0
`define LSD_ADDR_KEY1 3'h1
`define LSD_ADDR_KEY2 3'h2

// reset values
`define LSD_MODE_RESET 8'hFB
`define LSD_MEM_RESET 8'h00

// command byte fields
`define LSD_CMD_ADDR_LSB 1
`define LSD_CMD_PAGE_LSB 4
`define LSD_CMD_FIXED_BIT 6
`define LSD_CMD_READ_BIT 7

// mode location fields
`define LSD_DIGITS_LSB 0
`define LSD_BRIGHT_LSB 3
`define LSD_CONSTDIM_LSB 5
`define LSD_BRIGHT_CONST 2'h3
`define LSD_BRIGHT_VAR 2'h0
`define LSD_MAX_DIGCODE 3'h5

// timing
`define LSD_CLK_PERIOD_NS 25
`define LSD_KEY_CYCLE_US 64
`define LSD_DISP_CYCLE_US 512
`define LSD_KEY_CYCLE_CYC ((`LSD_KEY_CYCLE_US * 1000) / `LSD_CLK_PERIOD_NS)
`define LSD_DISP_CYCLE_CYC ((`LSD_DISP_CYCLE_US * 1000) / `LSD_CLK_PERIOD_NS)
`define LSD_KEY_LINES 8
`define LSD_DIM_SLOTS 16

`endif

// *** verilog/lsd_pkg.sv ***
// types for the led scan display controller
package lsd_pkg;

  typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_DATA} lsd_ser_t;

  typedef enum logic [1:0] {PH_KEY, PH_LED, PH_DIG} lsd_phase_t;

  typedef struct packed {
    logic [7:0] segment;
    logic [6:0] digit;
    logic key_active;
    logic data;
    logic data_oe;
  } lsd_pins_t;

  typedef struct packed {
    logic [2:0] stb_s;
    logic [2:0] sclk_s;
    logic [1:0] din_s;
    logic [1:0] key1_s;
    logic [1:0] key2_s;
    lsd_ser_t ser;
    logic [2:0] bits;
    logic [7:0] shift;
    logic [1:0] page;
    logic [2:0] ptr;
    logic fixed;
    logic rd;
    logic pend;
    logic [2:0] tx_bits;
    logic [7:0] tx;
    logic [5:0][7:0] seg_mem;
    logic [7:0] led_mem;
    logic led_written;
    logic [3:0][7:0] dig_dim;
    logic [3:0][7:0] led_dim;
    logic [15:0] keys;
    lsd_phase_t phase;
    logic [2:0] digit_drive;
    logic [10:0] sub;
    logic [3:0] idx;
    lsd_pins_t pins;
  } lsd_state_t;

endpackage

// *** sim/lsd_host.sv ***
// host side model of the three wire serial link
module lsd_host (
  input wire logic clk_sys_in,
  input wire logic bus_in,
  output logic sel_out,
  output logic sclk_out,
  output logic d_out,
  output logic oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sel_out = 1'b1;
    sclk_out = 1'b1;
    d_out = 1'b1;
    oe_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic start();
    sel_out = 1'b0;
    wt(40);
  endtask
  task automatic stop();
    wt(360);
    sel_out = 1'b1;
    oe_out = 1'b0;
    wt(40);
  endtask
  task automatic put(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      sclk_out = 1'b0;
      oe_out = 1'b1;
      d_out = b[i];
      wt(4);
      sclk_out = 1'b1;
      wt(4);
    end
  endtask
  task automatic get(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      sclk_out = 1'b0;
      oe_out = 1'b0;
      wt(4);
      b[i] = bus_in;
      sclk_out = 1'b1;
      wt(4);
    end
  endtask
endmodule

// *** sim/lsd_ctrl_sva.sv ***
// assertions on the led scan controller ports
`include "lsd_regs.svh"
module lsd_ctrl_sva #(
  parameter int DISP_CYC = 160
)
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic transfer_select_in,
  input wire logic data_oe_out,
  input wire logic [7:0] segment_out,
  input wire logic [6:0] digit_drive_out,
  input wire logic key_scan_line_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_reg;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // cycles the current digit cycle or whole key scan has lasted
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      run_reg <= 16'h0000;
    else if ($changed({digit_drive_out, key_scan_line_active_out}))
      run_reg <= 16'h0001;
    else
      run_reg <= run_reg + 16'h0001;
  end
  sequence s_key_end;
    $fell(key_scan_line_active_out);
  endsequence
  sequence s_first_slot;
    ##[0:1] (digit_drive_out[0] || digit_drive_out[1]);
  endsequence
  a_key_len: assert property (s_key_end |->
    run_reg == `LSD_KEY_CYCLE_CYC) else $error("key scan length wrong");
  a_digit_len: assert property (($changed(digit_drive_out) &&
    $past(digit_drive_out) != 7'h00) |-> run_reg == DISP_CYC)
    else $error("digit cycle length wrong");
  a_after_key: assert property (s_key_end |-> s_first_slot)
    else $error("no display cycle after key scan");
  a_key_lines: assert property (key_scan_line_active_out |->
    $onehot(segment_out)) else $error("key scan line not one-hot");
  a_key_dark: assert property (key_scan_line_active_out |->
    digit_drive_out == 7'h00) else $error("digit driven in key scan");
  a_one_digit: assert property ($onehot0(digit_drive_out))
    else $error("several digits driven");
  a_no_halt: assert property (($past(rstn_in) &&
    !key_scan_line_active_out) |-> digit_drive_out != 7'h00)
    else $error("scan halted");
  a_reset_key: assert property ($rose(rstn_in) |-> ##1
    (key_scan_line_active_out && segment_out == 8'h01))
    else $error("frame does not start with key scan");
  a_oe_idle: assert property (transfer_select_in [*5] |->
    !data_oe_out) else $error("data driven while deselected");
endmodule

bind lsd_ctrl lsd_ctrl_sva #(.DISP_CYC(DISP_CYC)) SVA (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .transfer_select_in(transfer_select_in), .data_oe_out(data_oe_out),
  .segment_out(segment_out), .digit_drive_out(digit_drive_out),
  .key_scan_line_active_out(key_scan_line_active_out));

// *** sim/tb.sv ***
// self-checking bench for the led scan controller
`include "lsd_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DC = 160;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [1:0] key_return_in = 2'h0;
  logic sel, sclk, hd, hoe, data_out, data_oe_out, key_on, ledw;
  logic [7:0] seg, b;
  logic [6:0] digit_drive;
  logic [7:0] mem [4][8];
  logic [7:0] q [$];
  wire logic bus;
  int err_total = 0;
  int checks_done = 0;
  // pull-up holds the line high when nobody drives
  assign bus = hoe ? hd : data_oe_out ? data_out : 1'b1;
  lsd_host HOST (.clk_sys_in(clk_sys_in), .bus_in(bus), .sel_out(sel),
    .sclk_out(sclk), .d_out(hd), .oe_out(hoe));
  lsd_ctrl #(.DISP_CYC(DC)) DUT (.clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in), .transfer_select_in(sel), .serial_clk_in(sclk),
    .data_in(bus), .data_out(data_out), .data_oe_out(data_oe_out),
    .key_return_in(key_return_in), .segment_out(seg),
    .digit_drive_out(digit_drive), .key_scan_line_active_out(key_on));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [2:0] lim(input logic [1:0] p);
    return p == 0 ? `LSD_LAST_SEG : p == 1 ? `LSD_LAST_LED : `LSD_LAST_DIM;
  endfunction
  function automatic logic [7:0] cmd(input logic [1:0] p,
    input logic [2:0] a, input logic f, r);
    return {r, f, p, a, 1'b0};
  endfunction
  function automatic int ont(input logic [2:0] c);
    return c < 3 ? 1 << c : c + 7;
  endfunction
  task automatic wr(input logic [1:0] p, input logic [2:0] a,
    input logic f, input int tail);
    HOST.start();
    HOST.put(cmd(p, a, f, 1'b0), 8);
    foreach (q[i])
    begin
      HOST.put(q[i], 8);
      if (p != 1 || a == 0) mem[p][a] = q[i];
      if (p == 1 && a == 0) ledw = 1'b1;
      if (!f) a = a == lim(p) ? 3'h0 : a + 3'h1;
    end
    if (tail > 0) HOST.put(8'hA5, tail);
    HOST.stop();
  endtask
  task automatic rd(input logic [1:0] p, input logic [2:0] a, input int n);
    HOST.start();
    HOST.put(cmd(p, a, 1'b0, 1'b1), 8);
    repeat (n)
    begin
      HOST.get(b);
      chk("read", b, mem[p][a]);
      a = a == lim(p) ? 3'h0 : a + 3'h1;
    end
    HOST.stop();
  endtask
  task automatic tick(inout int g);
    @(negedge clk_sys_in);
    g++;
  endtask
  task automatic frame();
    int g, k, j, nd;
    logic [7:0] m, d, n4;
    logic [6:0] pv;
    logic [31:0] c, on, e;
    logic ldc;
    g = 0;
    m = mem[2][0];
    nd = m[2:0] > 3'h5 ? 6 : m[2:0] + 1;
    while (key_on !== 1'b1 && g < 9000) tick(g);
    while (key_on !== 1'b0 && g < 9000) tick(g);
    k = 0;
    pv = 7'h00;
    on = 0;
    e = 0;
    while (key_on !== 1'b1 && g < 18000)
    begin
      if (digit_drive !== pv)
      begin
        if (k > 0) chk("on time", on, e);
        j = k - ledw;
        ldc = ledw && k == 0;
        d = ldc ? mem[1][0] : mem[0][j];
        n4 = j < 0 ? 8'h00 : mem[2][1 + j / 2] >> (4 * (j % 2));
        c = ldc ? {mem[3][3], mem[3][2], mem[3][1], mem[3][0]}
          : {8{n4[3:0]}};
        if (m[4:3] != 2'b00) c = {8{1'b0, m[7:5]}};
        e = 0;
        for (int i = 0; i < 8; i++)
          e += d[i] ? DC / 16 * ont(c[4 * i +: 3]) : 0;
        chk("digit", digit_drive, ldc ? 7'h01 : 7'h02 << j);
        pv = digit_drive;
        k++;
        on = 0;
      end
      on += $countones(seg);
      tick(g);
    end
    chk("on time", on, e);
    chk("cycles", k, nd + ledw);
    chk("frame wait", g < 18000, 1'b1);
  endtask
  initial
  begin
    key_return_in = 2'($urandom(49));
    foreach (mem[p, a]) mem[p][a] = 8'h00;
    mem[2][0] = `LSD_MODE_RESET;
    ledw = 1'b0;
    repeat (16) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    rd(2, 0, 4);
    rd(3, 0, 4);
    rd(0, 0, 7);
    frame();
    q = {};
    repeat (6) q.push_back(8'($urandom));
    wr(0, 0, 0, 0);
    rd(0, 0, 6);
    q = {8'h3C, 8'($urandom)};
    wr(0, 3, 1, 0);
    rd(0, 2, 3);
    q = {8'($urandom)};
    wr(0, 0, 0, 4);
    rd(0, 0, 2);
    b = {3'($urandom), 2'b11, 3'($urandom_range(5))};
    q = {b};
    wr(2, 0, 0, 0);
    frame();
    b = {3'($urandom), 2'b00, 3'($urandom_range(5))};
    q = {b, 8'($urandom), 8'($urandom), 8'($urandom)};
    wr(2, 0, 0, 0);
    frame();
    q = {8'($urandom)};
    wr(1, 0, 0, 0);
    q = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
    wr(3, 0, 0, 0);
    frame();
    mem[1][1] = {8{key_return_in[0]}};
    mem[1][2] = {8{key_return_in[1]}};
    rd(1, 0, 4);
    test_done();
  end
  initial
  begin
    repeat (95000) @(posedge clk_sys_in);
    err_total++;
    test_done();
  end
endmodule
